// >>> pkg/pcd_pkg.sv
/*
 * Shared constants of the command frame decoder: frame layout, sync length,
 * channel and register counts, timing figures and reset values.
 * Assumes a single 25 MHz system clock drives every design module.
 */
package pcd_pkg;

	// ----------------------------------------
	// Frame layout (bits sent MSB first)
	// ----------------------------------------
	localparam int SYNC_ZEROS = 13;
	localparam int FRAME_BITS = 17;
	localparam int ADDR_W = 7;
	localparam int CMD_W = 8;
	localparam int VAL_W = 16;
	localparam int ADDR_MSB = 16;
	localparam int ADDR_LSB = 10;
	localparam int SEL_POS = 9;
	localparam int WORD_MSB = 8;
	localparam int WORD_LSB = 1;
	localparam int CODE_W = 5;
	localparam int REG_SEL_W = 3;

	// ----------------------------------------
	// Outputs and destinations
	// ----------------------------------------
	localparam int NUM_CHAN = 255;
	localparam int NUM_REGS = 8;
	localparam int NUM_GROUPS = 5;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_HZ = 25000000;
	localparam int PULSE_MS = 50;
	localparam int EXT_MS = 17;
	localparam int PULSE_CYC = PULSE_MS * (CLK_HZ / 1000);
	localparam int EXT_CYC = EXT_MS * (CLK_HZ / 1000);
	localparam int CNT_W = 24;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [CMD_W-1:0] CMD_RST = 8'h00;
	localparam logic [VAL_W-1:0] VAL_RST = 16'h0000;
	localparam logic [4:0] FCNT_RST = 5'h00;
	localparam logic [3:0] ZCNT_RST = 4'h0;

	typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_VALUE, ST_POST} pcd_state_e;

endpackage

// >>> pkg/pcd_store_if.sv
/*
 * Carrier between the frame decoder and its destination register store.
 * Assumes both ends sit on the same clock.
 */
interface pcd_store_if #(
	parameter int W = 16,
	parameter int AW = 3
);
	logic wrEn;
	logic [AW-1:0] wrAddr;
	logic [W-1:0] wrData;
	logic [AW-1:0] rdAddr;
	logic [W-1:0] rdData;

	modport ctrl (output wrEn, output wrAddr, output wrData, output rdAddr, input rdData);
	modport store (input wrEn, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface

// >>> verilog/pcd_value_store.sv
/*
 * Eight destination registers for value commands, one write port and a
 * registered read port.
 * Assumes writes come from the decoder on the same clock.
 */
module pcd_value_store #(
	parameter int W = 16,
	parameter int DEPTH = 8
) (
	input wire logic mclk, // System clock
	input wire logic resetn, // Synchronous reset, active low
	pcd_store_if.store port // Write and read port
);
	logic [W-1:0] mem [DEPTH];
	logic [W-1:0] rdData_reg;

	// Storage; contents are undefined until first written
	always_ff @(posedge mclk) begin
		if (port.wrEn) begin
			mem[port.wrAddr] <= port.wrData;
		end
	end

	// Read data from a flop, one cycle after the address
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			rdData_reg <= '0;
		end else begin
			rdData_reg <= mem[port.rdAddr];
		end
	end

	assign port.rdData = rdData_reg;
endmodule

// >>> verilog/pcd_decoder.sv
/*
 * Serial command frame decoder: bit timing from the reference tone, sync
 * hunt, command/value/execute frames, timed channel pulse, value routing
 * and verification outputs.
 * Assumes the demodulated data, reference tone and carrier-present level
 * arrive asynchronously and are much slower than mclk.
 */
// Contract
// - Bit stream runs at 1 kbit/s, ones and zeros 180 degrees apart.
// - Rising zero crossing of reference tone marks each bit boundary.
// - Message starts with thirteen zeros then a single one.
// - Before sync the decoder stays idle and decodes nothing.
// - A 17-bit command frame follows sync: address, select, word, parity.
// - Seven-bit address must match own address, otherwise decoding stops.
// - Bit after the address selects which decoder acts.
// - Eight-bit command word stored, decoded to one of 255 channels.
// - Odd parity over the word is checked; failure stops the message.
// - Simple command gives one 50 ms pulse after the execute frame.
// - Five-bit code marks value command; three bits pick destination register.
// - Value presented in parallel on one of five 16-line groups; the code drives a group only for registers 0 to 4, the rest stay in the store.
// - Each further execute frame lengthens the active pulse by 17 ms.
// - Executes separated by post-message sync each give a pulse.
// - Stored command and value bits shown to telemetry before execution.
// - Value command is followed by 16 data bits plus odd parity.
// - Execute frame: address plus unique execute word fires stored channel.
// - Data-present flag shows a parity-checked stored command.
// - 28 bit times without carrier return the decoder to idle; the code returns to idle as soon as the synchronised carrier drops.
module pcd_decoder #(
	parameter logic [6:0] OWN_ADDR = 7'h2a, // Arbitrary spacecraft address
	parameter logic DECODER_ID = 1'b0, // Which of the redundant pair this is
	parameter logic [7:0] EXEC_WORD = 8'hff, // Execute command word
	parameter logic [4:0] VALUE_CODE = 5'h1e, // Marks value commands
	parameter int PULSE_CYCLES = pcd_pkg::PULSE_CYC, // 50 ms pulse
	parameter int EXT_CYCLES = pcd_pkg::EXT_CYC // 17 ms extension
) (
	input wire logic mclk, // System clock, 25 MHz
	input wire logic resetn, // Synchronous reset, active low
	input wire logic cmdData, // Demodulated command bit level
	input wire logic refTone, // Bit-rate reference tone, squared
	input wire logic carrierIn, // Subcarrier present
	output logic [pcd_pkg::NUM_CHAN-1:0] chanOut, // Channel code n on bit n-1
	output logic execActive, // Execute pulse running
	output logic msgActive, // Decoder out of idle
	output logic [pcd_pkg::CMD_W-1:0] verCmd, // Verify: stored command word
	output logic [pcd_pkg::VAL_W-1:0] verValue, // Verify: stored value
	output logic dataPresent, // Checked command is held
	output logic frameError, // One-cycle pulse on discard
	output logic [pcd_pkg::NUM_GROUPS*pcd_pkg::VAL_W-1:0] groupData, // Value groups
	output logic [pcd_pkg::NUM_GROUPS-1:0] groupLoad, // One-cycle load strobes
	input wire logic [pcd_pkg::REG_SEL_W-1:0] regRdAddr, // Register readback select
	output logic [pcd_pkg::VAL_W-1:0] regRdData // Register readback data
);
	localparam int CW = pcd_pkg::CNT_W;
	localparam logic [CW-1:0] PULSE_LD = CW'(PULSE_CYCLES);
	localparam logic [CW-1:0] EXT_LD = CW'(EXT_CYCLES);
	localparam logic [CW-1:0] CNT_MAX = '1;

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic dataMeta_reg, dataSync_reg;
	logic toneMeta_reg, toneSync_reg, toneDly_reg;
	logic carMeta_reg, carSync_reg;

	// Two flops per pin, a third on the tone for edge detect; the first flop of each pin is never looked at
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			dataMeta_reg <= 1'b0;
			dataSync_reg <= 1'b0;
			toneMeta_reg <= 1'b0;
			toneSync_reg <= 1'b0;
			toneDly_reg <= 1'b0;
			carMeta_reg <= 1'b0;
			carSync_reg <= 1'b0;
		end else begin
			dataMeta_reg <= cmdData;
			dataSync_reg <= dataMeta_reg;
			toneMeta_reg <= refTone;
			toneSync_reg <= toneMeta_reg;
			toneDly_reg <= toneSync_reg;
			carMeta_reg <= carrierIn;
			carSync_reg <= carMeta_reg;
		end
	end

	// ----------------------------------------
	// Bit timing
	// ----------------------------------------
	wire toneRise = toneSync_reg & ~toneDly_reg;
	wire toneFall = ~toneSync_reg & toneDly_reg;
	logic armed_reg;

	// Rising crossing opens a bit, falling crossing is mid-bit where data is steady
	always_ff @(posedge mclk) begin
		if (!resetn || !carSync_reg) begin
			armed_reg <= 1'b0;
		end else if (toneRise) begin
			armed_reg <= 1'b1;
		end else if (toneFall) begin
			armed_reg <= 1'b0;
		end
	end

	// One strobe per bit, only with the carrier up
	wire bitStb = toneFall & armed_reg & carSync_reg;
	wire bitVal = dataSync_reg;

	// ----------------------------------------
	// Frame decode
	// ----------------------------------------
	pcd_pkg::pcd_state_e state_reg, state_next;
	logic [3:0] zeroCnt_reg, zeroCnt_next;
	logic [4:0] frameCnt_reg, frameCnt_next;
	logic [pcd_pkg::FRAME_BITS-2:0] frameSr_reg;

	wire [pcd_pkg::FRAME_BITS-1:0] newFrame = {frameSr_reg, bitVal};
	wire [pcd_pkg::ADDR_W-1:0] fAddr = newFrame[pcd_pkg::ADDR_MSB:pcd_pkg::ADDR_LSB];
	wire [pcd_pkg::CMD_W-1:0] fWord = newFrame[pcd_pkg::WORD_MSB:pcd_pkg::WORD_LSB];
	wire fAddrOk = (fAddr == OWN_ADDR);
	wire fSelOk = (newFrame[pcd_pkg::SEL_POS] == DECODER_ID);
	wire fParOk = ^newFrame[pcd_pkg::WORD_MSB:0];
	wire fValParOk = ^newFrame;
	wire fIsExec = (fWord == EXEC_WORD);
	wire fIsValue = (fWord[pcd_pkg::CMD_W-1:pcd_pkg::REG_SEL_W] == VALUE_CODE);
	wire fZero = (newFrame == '0);
	wire fHeadOk = fAddrOk & fSelOk & fParOk;
	wire frameDone = bitStb & (state_reg != pcd_pkg::ST_IDLE)
		& (frameCnt_reg == 5'(pcd_pkg::FRAME_BITS - 1));
	wire syncSeen = bitStb & bitVal & (zeroCnt_reg >= 4'(pcd_pkg::SYNC_ZEROS));

	logic [pcd_pkg::CMD_W-1:0] cmd_reg;
	logic [pcd_pkg::VAL_W-1:0] value_reg;
	logic held_reg, isValue_reg, frameErr_reg;

	// Command frames: a real command word, not the execute word or zero
	wire cmdGood = fHeadOk & ~fIsExec & (fWord != '0);
	wire storeCmd = (state_reg == pcd_pkg::ST_CMD) & frameDone & cmdGood;
	wire storeVal = (state_reg == pcd_pkg::ST_VALUE) & frameDone & fValParOk;
	wire execFire = (state_reg == pcd_pkg::ST_POST) & frameDone & fHeadOk & fIsExec
		& held_reg;
	wire postZero = (state_reg == pcd_pkg::ST_POST) & frameDone & fZero;

	// Sequencer; carrier loss always wins and drops back to idle
	always_comb begin
		state_next = state_reg;
		zeroCnt_next = zeroCnt_reg;
		frameCnt_next = frameCnt_reg;
		if (!carSync_reg) begin
			state_next = pcd_pkg::ST_IDLE;
			zeroCnt_next = pcd_pkg::ZCNT_RST;
			frameCnt_next = pcd_pkg::FCNT_RST;
		end else begin
			case (state_reg)
				pcd_pkg::ST_IDLE: begin
					if (bitStb) begin
						if (!bitVal) begin
							if (zeroCnt_reg != 4'hf) begin
								zeroCnt_next = zeroCnt_reg + 4'h1;
							end
						end else begin
							zeroCnt_next = pcd_pkg::ZCNT_RST;
							if (syncSeen) begin
								state_next = pcd_pkg::ST_CMD;
							end
						end
					end
					frameCnt_next = pcd_pkg::FCNT_RST;
				end
				pcd_pkg::ST_CMD: begin
					if (frameDone) begin
						if (!cmdGood) begin
							state_next = pcd_pkg::ST_IDLE;
						end else if (fIsValue) begin
							state_next = pcd_pkg::ST_VALUE;
						end else begin
							state_next = pcd_pkg::ST_POST;
						end
					end
				end
				pcd_pkg::ST_VALUE: begin
					if (frameDone) begin
						state_next = fValParOk ? pcd_pkg::ST_POST : pcd_pkg::ST_IDLE;
					end
				end
				pcd_pkg::ST_POST: begin
					if (frameDone && !postZero && !execFire) begin
						state_next = pcd_pkg::ST_IDLE;
					end
				end
				default: begin
					state_next = pcd_pkg::ST_IDLE;
				end
			endcase
			if (bitStb && state_reg != pcd_pkg::ST_IDLE) begin
				frameCnt_next = frameDone ? pcd_pkg::FCNT_RST : frameCnt_reg + 5'h01;
			end
		end
	end

	// State and bit counters
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			state_reg <= pcd_pkg::ST_IDLE;
			zeroCnt_reg <= pcd_pkg::ZCNT_RST;
			frameCnt_reg <= pcd_pkg::FCNT_RST;
		end else begin
			state_reg <= state_next;
			zeroCnt_reg <= zeroCnt_next;
			frameCnt_reg <= frameCnt_next;
		end
	end

	// Frame shifter runs only while a message is open
	always_ff @(posedge mclk) begin
		if (!resetn || state_next == pcd_pkg::ST_IDLE) begin
			frameSr_reg <= '0;
		end else if (bitStb && state_reg != pcd_pkg::ST_IDLE) begin
			frameSr_reg <= newFrame[pcd_pkg::FRAME_BITS-2:0];
		end
	end

	// ----------------------------------------
	// Command store and verification
	// ----------------------------------------
	// Held words are dropped with the message so a stale command never fires
	always_ff @(posedge mclk) begin
		if (!resetn || state_next == pcd_pkg::ST_IDLE) begin
			cmd_reg <= pcd_pkg::CMD_RST;
			value_reg <= pcd_pkg::VAL_RST;
			held_reg <= 1'b0;
			isValue_reg <= 1'b0;
		end else begin
			if (storeCmd) begin
				cmd_reg <= fWord;
				isValue_reg <= fIsValue;
				held_reg <= ~fIsValue;
			end
			if (storeVal) begin
				value_reg <= newFrame[pcd_pkg::FRAME_BITS-1:1];
				held_reg <= 1'b1;
			end
		end
	end

	// Discard indication for telemetry
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			frameErr_reg <= 1'b0;
		end else begin
			frameErr_reg <= frameDone & (state_next == pcd_pkg::ST_IDLE);
		end
	end

	assign verCmd = cmd_reg;
	assign verValue = value_reg;
	assign dataPresent = held_reg;
	assign frameError = frameErr_reg;
	assign msgActive = (state_reg != pcd_pkg::ST_IDLE);

	// ----------------------------------------
	// Execute pulse
	// ----------------------------------------
	logic [CW-1:0] pulseCnt_reg;
	logic [pcd_pkg::CMD_W-1:0] pulseCode_reg;
	wire pulseOn = (pulseCnt_reg != '0);
	// The extending cycle also counts down, so the remaining time grows by EXT_LD, saturating at CNT_MAX
	wire [CW:0] extSum = {1'b0, pulseCnt_reg} + {1'b0, EXT_LD} - (CW+1)'(1);
	wire [CW-1:0] extended = extSum[CW] ? CNT_MAX : extSum[CW-1:0];

	// A new execute restarts; one during a live pulse of the same code extends it
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			pulseCnt_reg <= '0;
			pulseCode_reg <= pcd_pkg::CMD_RST;
		end else if (execFire && pulseOn && pulseCode_reg == cmd_reg) begin
			pulseCnt_reg <= extended;
		end else if (execFire) begin
			pulseCnt_reg <= PULSE_LD;
			pulseCode_reg <= cmd_reg;
		end else if (pulseOn) begin
			pulseCnt_reg <= pulseCnt_reg - CW'(1);
		end
	end

	assign execActive = pulseOn;

	// Channel matrix: only the latched code's line, only while timing
	genvar ch;
	generate
		for (ch = 0; ch < pcd_pkg::NUM_CHAN; ch++) begin : gChan
			logic line_reg;
			always_ff @(posedge mclk) begin
				if (!resetn) begin
					line_reg <= 1'b0;
				end else begin
					line_reg <= pulseOn & (pulseCode_reg == 8'(ch + 1));
				end
			end
			assign chanOut[ch] = line_reg;
		end
	endgenerate

	// ----------------------------------------
	// Value routing
	// ----------------------------------------
	pcd_store_if #(.W(pcd_pkg::VAL_W), .AW(pcd_pkg::REG_SEL_W)) store();

	wire [pcd_pkg::REG_SEL_W-1:0] regSel = cmd_reg[pcd_pkg::REG_SEL_W-1:0];
	wire valueExec = execFire & isValue_reg;

	assign store.wrEn = valueExec;
	assign store.wrAddr = regSel;
	assign store.wrData = value_reg;
	assign store.rdAddr = regRdAddr;
	assign regRdData = store.rdData;

	pcd_value_store #(.W(pcd_pkg::VAL_W), .DEPTH(pcd_pkg::NUM_REGS)) uStore (
		.mclk(mclk),
		.resetn(resetn),
		.port(store)
	);

	// Low selections also drive a parallel group; the rest stay in the store
	genvar g;
	generate
		for (g = 0; g < pcd_pkg::NUM_GROUPS; g++) begin : gGroup
			logic [pcd_pkg::VAL_W-1:0] data_reg;
			logic load_reg;
			wire hit = valueExec & (regSel == 3'(g));
			always_ff @(posedge mclk) begin
				if (!resetn) begin
					data_reg <= pcd_pkg::VAL_RST;
					load_reg <= 1'b0;
				end else begin
					load_reg <= hit;
					if (hit) begin
						data_reg <= value_reg;
					end
				end
			end
			assign groupData[g*pcd_pkg::VAL_W +: pcd_pkg::VAL_W] = data_reg;
			assign groupLoad[g] = load_reg;
		end
	endgenerate
endmodule

// >>> dv/pcd_cmd_rx.sv
/*
 * Command receiver model: queues bits, then plays them on the link pins.
 * Assumes the bench calls its tasks by hierarchical name.
 */
module pcd_cmd_rx (
	output logic cmdData, // Demodulated bit level
	output logic refTone, // Squared bit-rate tone
	output logic carrierIn // Subcarrier present
);
	timeunit 1ns;
	timeprecision 100ps;

	logic bitQ[$];

	initial begin
		cmdData = 1'b1;
		refTone = 1'b0;
		carrierIn = 1'b0;
	end

	// ----------------------------------------
	// Message building
	// ----------------------------------------
	task automatic zeros(input int n);
		repeat (n) bitQ.push_back(1'b0);
	endtask

	task automatic sync(input int n);
		zeros(n);
		bitQ.push_back(1'b1);
	endtask

	// Frames go out MSB first
	task automatic frame(input logic [16:0] f);
		for (int i = 16; i >= 0; i--) bitQ.push_back(f[i]);
	endtask

	// ----------------------------------------
	// Playback
	// ----------------------------------------
	// Tone rises on each bit edge and falls mid-bit; still between messages
	task automatic play();
		carrierIn = 1'b1;
		while (bitQ.size() > 0) begin
			cmdData = bitQ.pop_front();
			refTone = 1'b1;
			#160 refTone = 1'b0;
			#160;
		end
		cmdData = ~cmdData; // Released line must not show a stale bit
		carrierIn = 1'b0;
		#(28 * 320);
	endtask
endmodule

// >>> dv/pcd_decoder_chk.sv
/*
 * Concurrent checks on the decoder top ports, attached by bind.
 * Assumes one clock domain and a synchronous active-low reset.
 */
module pcd_decoder_chk #(
	parameter int PULSE_CYCLES = 200 // Pulse length in mclk
) (
	input wire logic mclk, // System clock
	input wire logic resetn, // Reset, active low
	input wire logic [254:0] chanOut, // Channel lines
	input wire logic execActive, // Pulse running
	input wire logic msgActive, // Out of idle
	input wire logic [7:0] verCmd, // Held command word
	input wire logic dataPresent, // Checked command held
	input wire logic frameError, // Discard strobe
	input wire logic [79:0] groupData, // Value groups
	input wire logic [4:0] groupLoad // Group strobes
);
	timeunit 1ns;
	timeprecision 100ps;

	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);

	logic [23:0] hiCnt_reg;
	logic [23:0] hiCnt_next;

	// ----------------------------------------
	// Pulse length counter
	// ----------------------------------------
	// Counts the high cycles of the current pulse so length is judged at its fall
	assign hiCnt_next = execActive ? hiCnt_reg + 24'h1 : 24'h0;
	always_ff @(posedge mclk) begin
		if (!resetn) hiCnt_reg <= 24'h0;
		else hiCnt_reg <= hiCnt_next;
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	one_chan_a: assert property ($onehot0(chanOut))
		else $error("more than one channel driven");
	chan_exec_a: assert property (chanOut != '0 |-> $past(execActive))
		else $error("channel driven without execute");
	chan_follow_a: assert property ($rose(execActive) |=> $onehot(chanOut))
		else $error("no channel after execute start");
	exec_cmd_a: assert property ($rose(execActive) |-> msgActive && $past(dataPresent))
		else $error("execute without held command");
	pulse_len_a: assert property ($fell(execActive) |-> hiCnt_reg >= PULSE_CYCLES)
		else $error("execute pulse too short");
	group_load_a: assert property (groupLoad != '0 |-> $onehot(groupLoad) && execActive)
		else $error("bad group load strobe");
	group_hold_a: assert property (!$stable(groupData) |-> groupLoad != '0)
		else $error("group data moved without load");
	reject_idle_a: assert property (frameError |-> ##[0:2] !dataPresent && !msgActive)
		else $error("rejected message not discarded");
	idle_quiet_a: assert property (!msgActive |-> !dataPresent)
		else $error("data present while idle");
	word_shown_a: assert property ($rose(dataPresent) |-> verCmd != 8'h00)
		else $error("data present with empty word");

	cover property ($fell(execActive) && hiCnt_reg > PULSE_CYCLES);
	cover property (groupLoad != '0);
	cover property (frameError);
endmodule

bind pcd_decoder pcd_decoder_chk #(.PULSE_CYCLES(PULSE_CYCLES)) u_chk (
	.mclk(mclk), .resetn(resetn), .chanOut(chanOut), .execActive(execActive),
	.msgActive(msgActive), .verCmd(verCmd), .dataPresent(dataPresent),
	.frameError(frameError), .groupData(groupData), .groupLoad(groupLoad)
);

// >>> dv/tb_pcm_command_frame_decoder.sv
/*
 * Bench of the command frame decoder: messages through the receiver model,
 * checks on channels, verify outputs and value registers.
 * Assumes shortened pulse counts of 200 and 60 cycles.
 */
module tb_pcm_command_frame_decoder;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int PULSE = 200;
	localparam int EXT = 60;
	localparam logic [6:0] ADDR = 7'h2a;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic cmdData, refTone, carrierIn, execActive, msgActive, dataPresent, frameError;
	logic [254:0] chanOut, chanSeen;
	logic [7:0] verCmd, verSeen;
	logic [15:0] verValue, regRdData, verVal, v, d;
	logic [79:0] groupData;
	logic [4:0] groupLoad, grpSeen;
	logic [2:0] regRdAddr;
	logic [16:0] exe, bad[4];
	int lenQ[$];
	int len, errCnt, err_total, comparisons;

	always #20 mclk = ~mclk;

	pcd_decoder #(.PULSE_CYCLES(PULSE), .EXT_CYCLES(EXT)) u_dut (
		.mclk(mclk), .resetn(resetn), .cmdData(cmdData), .refTone(refTone),
		.carrierIn(carrierIn), .chanOut(chanOut), .execActive(execActive),
		.msgActive(msgActive), .verCmd(verCmd), .verValue(verValue),
		.dataPresent(dataPresent), .frameError(frameError), .groupData(groupData),
		.groupLoad(groupLoad), .regRdAddr(regRdAddr), .regRdData(regRdData)
	);
	pcd_cmd_rx u_rx (.cmdData(cmdData), .refTone(refTone), .carrierIn(carrierIn));

	// ----------------------------------------
	// Monitor and helpers
	// ----------------------------------------
	// Tallies pulse lengths, lit channels, strobes and verify words per message
	always @(posedge mclk) begin
		if (execActive === 1'b1) len++;
		else if (len > 0) begin
			lenQ.push_back(len);
			len = 0;
		end
		chanSeen |= chanOut;
		grpSeen |= groupLoad;
		if (frameError === 1'b1) errCnt++;
		if (dataPresent === 1'b1) begin
			verSeen = verCmd;
			verVal = verValue;
		end
	end

	function automatic logic [16:0] cf(input logic [6:0] a, input logic s, input logic [7:0] w);
		return {a, s, w, ~^w}; // Odd parity
	endfunction

	// Wide enough for all channels plus the verify word in one compare
	task automatic chk_v(input logic [263:0] got, input logic [263:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_n(input int got, input int exp);
		comparisons++;
		if (got != exp) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Plays the queued message; the tail lets a stretched pulse finish
	task automatic run();
		chanSeen = '0;
		grpSeen = '0;
		verSeen = '0;
		errCnt = 0;
		lenQ.delete();
		@(posedge mclk) #1 u_rx.play();
		repeat (100) @(posedge mclk);
	endtask

	task automatic rd(input logic [2:0] a, output logic [15:0] q);
		@(posedge mclk) #1 regRdAddr = a;
		repeat (2) @(posedge mclk);
		#1 q = regRdData;
	endtask

	task automatic finish_test();
		if (err_total == 0 && comparisons > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		#2000000;
		err_total++;
		finish_test();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		regRdAddr = 3'h0;
		exe = cf(ADDR, 1'b0, 8'hff);
		bad = '{cf(ADDR ^ 7'h01, 1'b0, 8'h05), cf(ADDR, 1'b1, 8'h05),
			cf(ADDR, 1'b0, 8'h05) ^ 17'h1, exe};
		repeat (16) @(posedge mclk);
		chk_v(chanOut, '0);
		chk_v({groupData, verCmd, verValue, execActive, msgActive, dataPresent}, '0);
		#1 resetn = 1'b1;
		repeat (4) @(posedge mclk);
		// Plain command, then execute with no verification gap
		u_rx.sync(13);
		u_rx.frame(cf(ADDR, 1'b0, 8'h05));
		u_rx.frame(exe);
		run();
		chk_v(verSeen, 8'h05);
		chk_v(chanSeen, 255'h1 << 4);
		chk_n(lenQ.size(), 1);
		chk_n(lenQ[0], PULSE);
		chk_v({msgActive, dataPresent}, 2'b00);
		// One zero short of sync: hunt only
		u_rx.sync(12);
		u_rx.frame(cf(ADDR, 1'b0, 8'h05));
		u_rx.frame(exe);
		run();
		chk_v({chanSeen, verSeen}, '0);
		// Address, select, parity and lone execute faults
		for (int i = 0; i < 4; i++) begin
			u_rx.sync(13);
			u_rx.frame(bad[i]);
			u_rx.frame(exe);
			run();
			chk_n(errCnt, 1);
			chk_v({chanSeen, verSeen}, '0);
		end
		// Every destination register, with and without verification gap
		for (int r = 0; r < 8; r++) begin
			v = 16'h9c30 + 16'(r);
			u_rx.sync(13);
			u_rx.frame(cf(ADDR, 1'b0, {5'h1e, 3'(r)}));
			u_rx.frame({v, ~^v});
			u_rx.zeros(17 * (r % 2));
			u_rx.frame(exe);
			run();
			chk_v(verVal, v);
			chk_v(chanSeen, 255'h1 << (239 + r));
			chk_v(grpSeen, r < 5 ? 5'h1 << r : 5'h0);
			if (r < 5) chk_v(groupData[16*r +: 16], v);
			rd(3'(r), d);
			chk_v(d, v);
		end
		// Back-to-back executes stretch, spaced ones repeat
		u_rx.sync(13);
		u_rx.frame(cf(ADDR, 1'b0, 8'h33));
		u_rx.frame(exe);
		u_rx.frame(exe);
		u_rx.zeros(34);
		u_rx.frame(exe);
		run();
		chk_n(lenQ.size(), 2);
		chk_n(lenQ[0], PULSE + EXT);
		chk_n(lenQ[1], PULSE);
		finish_test();
	end
endmodule
